// file: lmf_regs.sv
/*
  lmf_regs: function register page of an 18x4 LED matrix driver, reached
  over the SPI pins, with decoded controls for the scan engine.
  Assumes: spi pins are asynchronous and sck is slow against clk (4x or
  more); fault_flags, fault_done, dot_sel come from logic on clk.
*/
// Function
// R1 - one reset-to-zero scaling byte per dot at 0x01..0x48, 256 steps
// R2 - peak current scales with gain/256 times dot scale/256
// R3 - config 0x50: scan select 7:4, detect select 2:1, run bit 0
// R4 - run bit 0 keeps shutdown; host sets it to 1 to run
// R5 - detect select: 00 off, 01 open, 10 short
// R6 - 01 or 10 starts one pass; host rewrites 00 before next pass
// R7 - twelve read-only result registers 0x53..0x5E, six flags, 7:6 zero
// R8 - host sets gain 0x0F..0x40 and pull register 0x00 before detecting
// R9 - scan select: 1 three rows, 2 two rows, 3 no scan, others four
// R10 - global gain at 0x51 scales all column sinks, resets to zero
// R11 - pull register 0x52: phase 7, row pulldown 6:4, column pullup 2:0
// R12 - phase bit 0 no delay, 1 gives 180 degree phase delay
// R13 - row pulldown: 000 none, 001-011 off-time only, 100-111 always
// R14 - column pullup: 000 none, 001-011 off-time only, 100-111 always
// R15 - over temperature derates current to 100, 75, 55 or 30 percent
// R16 - thermal threshold 3:2 of 0x5F: 00 140 C, 01 120 C
// R17 - 0x60 bit 4 enables spread spectrum, range 3:2, period 1:0
// R18 - spread range codes give 5, 15, 24, 34 percent deviation
// R19 - spread period codes give 1980, 1200, 820, 660 us
// R20 - writing 0xAE to 0x8F restores every register default; results load fault_flags instead if fault_done is high that cycle
// R21 - power-up reset loads every default, display blank
// R22 - writes to 0xE2 apply only while 0xE0 bit 0 is set
// R23 - host waits two scan cycles before reading results
// R24 - frequency code 7:5: 000/111 full rate, 001..110 halve each step
// R25 - host selects function page 0x41 in the command byte
// R26 - reserved bits read zero; unsupported directions are ignored
`timescale 1ns/1ps
module lmf_regs #(
  parameter int NUM_DOTS = 72
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic [71:0] fault_flags,
  input wire logic fault_done,
  input wire logic over_temp,
  input wire logic [6:0] dot_sel,
  output logic [15:0] dot_peak_q,
  output logic [6:0] derate_pct_q,
  output logic run_not_shutdown_q,
  output logic [2:0] scan_rows_q,
  output logic detect_start,
  output logic [1:0] fault_detect_select_q,
  output logic [7:0] global_current_gain_q,
  output logic phase_choice_bit_q,
  output logic [4:0] row_pull_halfk_q,
  output logic row_pull_always_q,
  output logic [4:0] col_pull_halfk_q,
  output logic col_pull_always_q,
  output logic [1:0] thermal_threshold_q,
  output logic spread_enable_q,
  output logic [5:0] spread_pct_q,
  output logic [10:0] spread_period_us_q,
  output logic [2:0] pwm_freq_shift_q
);
  if (NUM_DOTS < 1 || NUM_DOTS > 72) begin : g_bad_dots
    $error("NUM_DOTS must be 1..72");
  end

  // resistor code to half-kilohm units
  function automatic logic [4:0] pull_halfk(input logic [2:0] code);
    unique case (code)
      3'h0: pull_halfk = 5'h00;
      3'h1: pull_halfk = 5'h01;
      3'h2, 3'h4: pull_halfk = 5'h02;
      3'h3, 3'h5: pull_halfk = 5'h04;
      3'h6: pull_halfk = 5'h08;
      default: pull_halfk = 5'h10;
    endcase
  endfunction : pull_halfk

  // two-flop synchronisers; stage 3 only for edge finding
  logic cs_s1_q, cs_s2_q, sck_s1_q, sck_s2_q, sck_s3_q, mosi_s1_q, mosi_s2_q;
  logic temp_s1_q, temp_s2_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
      temp_s1_q <= 1'b0;
      temp_s2_q <= 1'b0;
    end else begin
      cs_s1_q <= spi_cs_n;
      cs_s2_q <= cs_s1_q;
      sck_s1_q <= spi_sck;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      mosi_s1_q <= spi_mosi;
      mosi_s2_q <= mosi_s1_q;
      temp_s1_q <= over_temp;
      temp_s2_q <= temp_s1_q;
    end
  end

  logic sck_rise, sck_fall, active;
  assign active = !cs_s2_q;
  assign sck_rise = active && sck_s2_q && !sck_s3_q;
  assign sck_fall = active && !sck_s2_q && sck_s3_q;

  // serial framing
  lmf_pkg::lmf_phase_t phase_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q, addr_q, tx_q;
  logic read_q, byte_done, wr_stb;
  logic [7:0] byte_in, rd_data;
  assign byte_in = {shift_q[6:0], mosi_s2_q};
  assign byte_done = sck_rise && (bit_cnt_q == 3'h7);
  assign wr_stb = byte_done && (phase_q == lmf_pkg::PH_DATA) && !read_q;

  always_ff @(posedge clk) begin
    if (!rst_n || !active) begin
      phase_q <= lmf_pkg::PH_CMD;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      read_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= byte_in;
      if (bit_cnt_q == 3'h7) begin
        unique case (phase_q)
          lmf_pkg::PH_CMD: begin
            // R25 only the function page answers
            read_q <= byte_in[lmf_pkg::CMD_RW_BIT];
            if (byte_in[6:4] == lmf_pkg::CMD_CHIP_ID && byte_in[3:0] == lmf_pkg::CMD_FUNC_PAGE)
              phase_q <= lmf_pkg::PH_ADDR;
            else
              phase_q <= lmf_pkg::PH_SKIP;
          end
          lmf_pkg::PH_ADDR: begin
            addr_q <= byte_in;
            phase_q <= lmf_pkg::PH_DATA;
          end
          lmf_pkg::PH_DATA: addr_q <= addr_q + 8'h01;
          lmf_pkg::PH_SKIP: phase_q <= lmf_pkg::PH_SKIP;
        endcase
      end
    end
  end

  // readback shifter: loaded on 8th rise, shifted on later falls
  logic [7:0] rd_addr;
  assign rd_addr = (phase_q == lmf_pkg::PH_ADDR) ? byte_in : addr_q + 8'h01;
  logic [7:0] rd_next;
  always_ff @(posedge clk) begin
    if (!rst_n || !active) begin
      tx_q <= 8'h00;
      spi_miso_oe <= 1'b0;
    end else if (byte_done && read_q &&
                 (phase_q == lmf_pkg::PH_ADDR || phase_q == lmf_pkg::PH_DATA)) begin
      tx_q <= rd_next;
      spi_miso_oe <= 1'b1;
    end else if (sck_fall && bit_cnt_q != 3'h0) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end
  assign spi_miso = tx_q[7];

  // register storage
  logic [7:0] dot_scale_q [NUM_DOTS];
  logic [7:0] config_q, pull_q, thermal_q, spread_q, unlock_q, freq_q;
  logic [5:0] fault_q [lmf_pkg::FAULT_REGS];
  logic det_armed_q, clear_all;
  logic [7:0] wdata;
  assign wdata = byte_in;
  // R20 soft reset key
  assign clear_all = !rst_n || (wr_stb && addr_q == lmf_pkg::OFS_SOFT_RESET &&
                                wdata == lmf_pkg::SOFT_RESET_KEY);

  // R1 dot scaling bytes
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_DOTS; i++) begin
      if (clear_all)
        dot_scale_q[i] <= lmf_pkg::RST_ZERO;
      else if (wr_stb && addr_q == lmf_pkg::OFS_DOT_FIRST + 8'(i))
        dot_scale_q[i] <= wdata;
    end
  end

  // R21 power-up defaults
  always_ff @(posedge clk) begin
    if (clear_all) begin
      config_q <= lmf_pkg::RST_ZERO;
      global_current_gain_q <= lmf_pkg::RST_ZERO;
      pull_q <= lmf_pkg::RST_PULL;
      thermal_q <= lmf_pkg::RST_ZERO;
      spread_q <= lmf_pkg::RST_ZERO;
      unlock_q <= lmf_pkg::RST_ZERO;
    end else if (wr_stb) begin
      // R26 reserved bits masked off
      unique case (addr_q)
        // R3 config fields
        lmf_pkg::OFS_CONFIG: config_q <= wdata & lmf_pkg::MASK_CONFIG;
        // R10 global gain
        lmf_pkg::OFS_GAIN: global_current_gain_q <= wdata;
        // R11 pull fields
        lmf_pkg::OFS_PULL: pull_q <= wdata & lmf_pkg::MASK_PULL;
        lmf_pkg::OFS_THERMAL: thermal_q <= wdata & lmf_pkg::MASK_THERMAL;
        lmf_pkg::OFS_SPREAD: spread_q <= wdata & lmf_pkg::MASK_SPREAD;
        lmf_pkg::OFS_FREQ_UNLOCK: unlock_q <= {7'h00, wdata[lmf_pkg::UNLOCK_BIT]};
        default: unlock_q <= unlock_q;
      endcase
    end
  end

  // R22 frequency code gated by unlock
  always_ff @(posedge clk) begin
    if (clear_all)
      freq_q <= lmf_pkg::RST_ZERO;
    else if (wr_stb && addr_q == lmf_pkg::OFS_FREQ_SELECT && unlock_q[lmf_pkg::UNLOCK_BIT])
      freq_q <= {wdata[7:5], 5'h00};
  end

  // R6 one pass per 00 -> 01/10 sequence
  logic [1:0] det_new;
  logic det_fire;
  assign det_new = wdata[lmf_pkg::CFG_DET_LSB +: 2];
  assign det_fire = wr_stb && addr_q == lmf_pkg::OFS_CONFIG && det_armed_q &&
                    (det_new == lmf_pkg::DET_OPEN || det_new == lmf_pkg::DET_SHORT);
  always_ff @(posedge clk) begin
    if (clear_all) begin
      det_armed_q <= 1'b1;
      detect_start <= 1'b0;
    end else begin
      detect_start <= det_fire;
      if (det_fire)
        det_armed_q <= 1'b0;
      else if (wr_stb && addr_q == lmf_pkg::OFS_CONFIG && det_new == lmf_pkg::DET_OFF)
        det_armed_q <= 1'b1;
    end
  end

  // R7 results captured from the scan engine
  always_ff @(posedge clk) begin
    for (int i = 0; i < lmf_pkg::FAULT_REGS; i++) begin
      if (!rst_n || (clear_all && !fault_done))
        fault_q[i] <= 6'h00;
      else if (fault_done)
        fault_q[i] <= fault_flags[i*lmf_pkg::FAULT_COLS +: lmf_pkg::FAULT_COLS];
    end
  end

  // readback mux; R26 write-only and unmapped read as zero
  logic [7:0] fidx;
  assign fidx = rd_addr - lmf_pkg::OFS_FAULT_FIRST;
  always_comb begin
    rd_data = 8'h00;
    if (rd_addr >= lmf_pkg::OFS_DOT_FIRST &&
        rd_addr < lmf_pkg::OFS_DOT_FIRST + 8'(NUM_DOTS))
      rd_data = dot_scale_q[7'(rd_addr - lmf_pkg::OFS_DOT_FIRST)];
    else if (rd_addr >= lmf_pkg::OFS_FAULT_FIRST && rd_addr <= lmf_pkg::OFS_FAULT_LAST)
      rd_data = {2'b00, fault_q[4'(fidx)]};
    else if (rd_addr == lmf_pkg::OFS_CONFIG)
      rd_data = config_q;
    else if (rd_addr == lmf_pkg::OFS_GAIN)
      rd_data = global_current_gain_q;
    else if (rd_addr == lmf_pkg::OFS_PULL)
      rd_data = pull_q;
    else if (rd_addr == lmf_pkg::OFS_THERMAL)
      rd_data = thermal_q;
    else if (rd_addr == lmf_pkg::OFS_SPREAD)
      rd_data = spread_q;
  end
  assign rd_next = rd_data;

  // decoded controls, registered for clean timing into the analog side
  logic [3:0] scan_sel;
  logic [7:0] sel_scale;
  assign scan_sel = config_q[lmf_pkg::CFG_SCAN_LSB +: 4];
  assign sel_scale = (dot_sel < 7'(NUM_DOTS)) ? dot_scale_q[dot_sel] : 8'h00;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dot_peak_q <= 16'h0000;
      derate_pct_q <= 7'd100;
      run_not_shutdown_q <= 1'b0;
      scan_rows_q <= 3'h4;
      fault_detect_select_q <= 2'h0;
      phase_choice_bit_q <= 1'b0;
      row_pull_halfk_q <= 5'h00;
      row_pull_always_q <= 1'b0;
      col_pull_halfk_q <= 5'h00;
      col_pull_always_q <= 1'b0;
      thermal_threshold_q <= 2'h0;
      spread_enable_q <= 1'b0;
      spread_pct_q <= 6'h00;
      spread_period_us_q <= 11'h000;
      pwm_freq_shift_q <= 3'h0;
    end else begin
      // R2 gain times dot scale, in 1/65536 of full scale
      dot_peak_q <= global_current_gain_q * sel_scale;
      // R15 derate only while hot
      if (!temp_s2_q)
        derate_pct_q <= 7'd100;
      else
        unique case (thermal_q[lmf_pkg::THERM_DER_LSB +: 2])
          2'h0: derate_pct_q <= 7'd100;
          2'h1: derate_pct_q <= 7'd75;
          2'h2: derate_pct_q <= 7'd55;
          2'h3: derate_pct_q <= 7'd30;
        endcase
      // R4 shutdown while run bit clear
      run_not_shutdown_q <= config_q[lmf_pkg::CFG_RUN_BIT];
      // R9 rows scanned, zero means sinks only
      unique case (scan_sel)
        lmf_pkg::SCAN_ROWS3: scan_rows_q <= 3'h3;
        lmf_pkg::SCAN_ROWS2: scan_rows_q <= 3'h2;
        lmf_pkg::SCAN_NONE: scan_rows_q <= 3'h0;
        default: scan_rows_q <= 3'h4;
      endcase
      // R5 detection mode, 11 treated as off
      fault_detect_select_q <= (config_q[lmf_pkg::CFG_DET_LSB +: 2] == 2'h3) ?
                               lmf_pkg::DET_OFF : config_q[lmf_pkg::CFG_DET_LSB +: 2];
      // R12 phase delay select
      phase_choice_bit_q <= pull_q[lmf_pkg::PULL_PHASE_BIT];
      // R13 row pulldown
      row_pull_halfk_q <= pull_halfk(pull_q[lmf_pkg::PULL_ROW_LSB +: 3]);
      row_pull_always_q <= pull_q[lmf_pkg::PULL_ROW_LSB + 2];
      // R14 column pullup
      col_pull_halfk_q <= pull_halfk(pull_q[lmf_pkg::PULL_COL_LSB +: 3]);
      col_pull_always_q <= pull_q[lmf_pkg::PULL_COL_LSB + 2];
      // R16 threshold code
      thermal_threshold_q <= thermal_q[lmf_pkg::THERM_THR_LSB +: 2];
      // R17 spread enable
      spread_enable_q <= spread_q[lmf_pkg::SPR_EN_BIT];
      // R18 spread range
      unique case (spread_q[lmf_pkg::SPR_RANGE_LSB +: 2])
        2'h0: spread_pct_q <= 6'd5;
        2'h1: spread_pct_q <= 6'd15;
        2'h2: spread_pct_q <= 6'd24;
        2'h3: spread_pct_q <= 6'd34;
      endcase
      // R19 spread period
      unique case (spread_q[lmf_pkg::SPR_PERIOD_LSB +: 2])
        2'h0: spread_period_us_q <= 11'd1980;
        2'h1: spread_period_us_q <= 11'd1200;
        2'h2: spread_period_us_q <= 11'd820;
        2'h3: spread_period_us_q <= 11'd660;
      endcase
      // R24 divide exponent, 111 same as 000
      pwm_freq_shift_q <= (freq_q[7:5] == 3'h7) ? 3'h0 : freq_q[lmf_pkg::FREQ_CODE_LSB +: 3];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_soft_reset;
    wr_stb && addr_q == lmf_pkg::OFS_SOFT_RESET && wdata == lmf_pkg::SOFT_RESET_KEY;
  endsequence
  sequence s_defaults;
    config_q == 8'h00 && pull_q == 8'h33 && freq_q == 8'h00 && !unlock_q[0];
  endsequence

  chk_soft_reset_defaults: assert property (s_soft_reset |=> s_defaults) // R20
    else $error("soft reset did not restore defaults");
  chk_detect_single_pass: assert property (detect_start |-> !det_armed_q ##1 !detect_start) // R6
    else $error("detection started twice");
  chk_detect_needs_arm: assert property (wr_stb && addr_q == lmf_pkg::OFS_CONFIG && // R6
                                         !det_armed_q |=> !detect_start)
    else $error("detect fired without arming");
  chk_freq_locked: assert property (wr_stb && addr_q == lmf_pkg::OFS_FREQ_SELECT &&
                                    !unlock_q[0] |=> $stable(freq_q)) // R22
    else $error("frequency changed while locked");
  chk_scan_none: assert property (scan_sel == 4'h3 |=> scan_rows_q == 3'h0) // R9
    else $error("no-scan code still scans");
  chk_run_follows_bit: assert property (!config_q[0] |=> !run_not_shutdown_q) // R4
    else $error("running while shut down");
  chk_peak_product: assert property (##1 dot_peak_q ==
                                     $past(global_current_gain_q) * $past(sel_scale)) // R2
    else $error("peak scale wrong");
  chk_derate_hot: assert property (temp_s2_q && thermal_q[1:0] == 2'h3 |=>
                                   derate_pct_q == 7'd30) // R15
    else $error("derate level wrong");
  chk_fault_read_upper: assert property (rd_addr >= 8'h53 && rd_addr <= 8'h5E |->
                                         rd_data[7:6] == 2'b00) // R7
    else $error("result upper bits set");
  chk_pull_reserved: assert property (pull_q[3] == 1'b0 && config_q[3] == 1'b0) // R26
    else $error("reserved bit set");
endmodule : lmf_regs

// file: lmf_pkg.sv
/*
  lmf_pkg: offsets, field positions, reset values and encodings of the
  function page of the LED matrix driver.
  Assumes: used by lmf_regs only, always through lmf_pkg::name.
*/
package lmf_pkg;
  // command byte
  localparam logic [2:0] CMD_CHIP_ID = 3'h4;
  localparam logic [3:0] CMD_FUNC_PAGE = 4'h1;
  localparam int CMD_RW_BIT = 7;
  // register offsets
  localparam logic [7:0] OFS_DOT_FIRST = 8'h01;
  localparam logic [7:0] OFS_CONFIG = 8'h50;
  localparam logic [7:0] OFS_GAIN = 8'h51;
  localparam logic [7:0] OFS_PULL = 8'h52;
  localparam logic [7:0] OFS_FAULT_FIRST = 8'h53;
  localparam logic [7:0] OFS_FAULT_LAST = 8'h5E;
  localparam logic [7:0] OFS_THERMAL = 8'h5F;
  localparam logic [7:0] OFS_SPREAD = 8'h60;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h8F;
  localparam logic [7:0] OFS_FREQ_UNLOCK = 8'hE0;
  localparam logic [7:0] OFS_FREQ_SELECT = 8'hE2;
  // reset values and keys
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PULL = 8'h33;
  localparam logic [7:0] SOFT_RESET_KEY = 8'hAE;
  // writable masks (reserved bits read zero)
  localparam logic [7:0] MASK_CONFIG = 8'hF7;
  localparam logic [7:0] MASK_PULL = 8'hF7;
  localparam logic [7:0] MASK_THERMAL = 8'h0F;
  localparam logic [7:0] MASK_SPREAD = 8'h1F;
  // field positions
  localparam int CFG_SCAN_LSB = 4;
  localparam int CFG_DET_LSB = 1;
  localparam int CFG_RUN_BIT = 0;
  localparam int PULL_PHASE_BIT = 7;
  localparam int PULL_ROW_LSB = 4;
  localparam int PULL_COL_LSB = 0;
  localparam int THERM_THR_LSB = 2;
  localparam int THERM_DER_LSB = 0;
  localparam int SPR_EN_BIT = 4;
  localparam int SPR_RANGE_LSB = 2;
  localparam int SPR_PERIOD_LSB = 0;
  localparam int UNLOCK_BIT = 0;
  localparam int FREQ_CODE_LSB = 5;
  localparam int FAULT_COLS = 6;
  localparam int FAULT_REGS = 12;
  // encodings
  localparam logic [1:0] DET_OFF = 2'h0;
  localparam logic [1:0] DET_OPEN = 2'h1;
  localparam logic [1:0] DET_SHORT = 2'h2;
  localparam logic [3:0] SCAN_ROWS3 = 4'h1;
  localparam logic [3:0] SCAN_ROWS2 = 4'h2;
  localparam logic [3:0] SCAN_NONE = 4'h3;
  typedef enum logic [3:0] {
    PH_CMD = 4'b0001,
    PH_ADDR = 4'b0010,
    PH_DATA = 4'b0100,
    PH_SKIP = 4'b1000
  } lmf_phase_t;
endpackage : lmf_pkg

// file: lmf_spi_host.sv
/*
  lmf_spi_host: spi master model standing in for the microcontroller,
  mode 0, msb first, one frame per call.
  Assumes: clk at 25 MHz, sck period of eight clk, miso pulled up while
  the device does not drive it.
*/
`timescale 1ns/1ps
module lmf_spi_host (
  input wire logic clk,
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  logic [7:0] wbuf [16];
  logic [7:0] rbuf [16];
  logic oe_seen;
  // pull-up, so an undriven miso never repeats the last bit
  wire logic miso_line = spi_miso_oe ? spi_miso : 1'b1;

  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
    oe_seen = 1'b0;
  end

  // mosi moves on sck fall, miso taken just before sck rises
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi <= tx[i];
      repeat (4) @(posedge clk);
      rx[i] = miso_line;
      oe_seen = oe_seen | spi_miso_oe;
      spi_sck <= 1'b1;
      repeat (4) @(posedge clk);
      spi_sck <= 1'b0;
    end
  endtask : xfer_byte

  task automatic frame(input logic [7:0] cmd, input logic [7:0] addr, input int n);
    logic [7:0] junk;
    @(posedge clk);
    oe_seen = 1'b0;
    spi_cs_n <= 1'b0;
    repeat (2) @(posedge clk);
    xfer_byte(cmd, junk);
    xfer_byte(addr, junk);
    for (int k = 0; k < n; k++) begin
      xfer_byte(wbuf[k], rbuf[k]);
    end
    repeat (4) @(posedge clk);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    // idle gap well above the sync chain depth
    repeat (6) @(posedge clk);
  endtask : frame
endmodule : lmf_spi_host

// file: tb.sv
/*
  tb: self-checking bench for lmf_regs, registers reached by spi frames.
  Assumes: lmf_spi_host plays the microcontroller; scan engine inputs are
  driven here.
*/
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
  logic [71:0] fault_flags;
  logic fault_done, over_temp, detect_start, run_not_shutdown_q, phase_choice_bit_q;
  logic row_pull_always_q, col_pull_always_q, spread_enable_q;
  logic [6:0] dot_sel, derate_pct_q;
  logic [15:0] dot_peak_q;
  logic [2:0] scan_rows_q, pwm_freq_shift_q;
  logic [1:0] fault_detect_select_q, thermal_threshold_q;
  logic [7:0] global_current_gain_q;
  logic [4:0] row_pull_halfk_q, col_pull_halfk_q;
  logic [5:0] spread_pct_q;
  logic [10:0] spread_period_us_q;
  int n_errors, n_tests, starts;
  localparam logic [71:0] FLAGS = 72'hA5_C396_F01E_2D3C_4B5A;
  logic [2:0] exp_rows [6] = '{3'h4, 3'h3, 3'h2, 3'h0, 3'h4, 3'h4};
  logic [4:0] exp_halfk [8] = '{5'h0, 5'h1, 5'h2, 5'h4, 5'h2, 5'h4, 5'h8, 5'h10};
  logic [6:0] exp_der [4] = '{7'h64, 7'h4B, 7'h37, 7'h1E};
  logic [5:0] exp_pct [4] = '{6'h05, 6'h0F, 6'h18, 6'h22};
  logic [10:0] exp_per [4] = '{11'h7BC, 11'h4B0, 11'h334, 11'h294};

  lmf_regs dut (.clk, .rst_n, .spi_cs_n, .spi_sck, .spi_mosi, .spi_miso, .spi_miso_oe,
    .fault_flags, .fault_done, .over_temp, .dot_sel, .dot_peak_q, .derate_pct_q,
    .run_not_shutdown_q, .scan_rows_q, .detect_start, .fault_detect_select_q,
    .global_current_gain_q, .phase_choice_bit_q, .row_pull_halfk_q, .row_pull_always_q,
    .col_pull_halfk_q, .col_pull_always_q, .thermal_threshold_q, .spread_enable_q,
    .spread_pct_q, .spread_period_us_q, .pwm_freq_shift_q);
  lmf_spi_host host (.clk, .spi_cs_n, .spi_sck, .spi_mosi, .spi_miso, .spi_miso_oe);

  always #20 clk = ~clk;
  // count pulses, so a stretched pulse shows as extra passes
  always @(posedge clk) begin
    if (detect_start === 1'b1) begin
      starts <= starts + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.wbuf[0] = d;
    host.frame(8'h41, a, 1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n);
    host.frame(8'hC1, a, n);
  endtask : rd
  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask : tend
  task automatic stop_test;
    $display("compared %0d, mismatched %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    stop_test();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    fault_flags = '0;
    fault_done = 1'b0;
    over_temp = 1'b0;
    dot_sel = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check(derate_pct_q, 32'h64);
    check(scan_rows_q, 32'h4);
    check(row_pull_halfk_q, 32'h4);
    rd(8'h50, 3);
    check(host.rbuf[0], 32'h0);
    check(host.rbuf[1], 32'h0);
    check(host.rbuf[2], 32'h33);
    tend("reset");
    wr(8'h51, 8'hFF);
    host.wbuf[0] = 8'h7F;
    host.wbuf[1] = 8'hFF;
    host.frame(8'h41, 8'h47, 2);
    rd(8'h47, 3);
    check(host.rbuf[0], 32'h7F);
    check(host.rbuf[1], 32'hFF);
    check(host.rbuf[2], 32'h0);
    dot_sel <= 7'h46;
    repeat (3) @(posedge clk);
    check(dot_peak_q, 32'h7E81);
    dot_sel <= 7'h47;
    repeat (3) @(posedge clk);
    check(dot_peak_q, 32'hFE01);
    dot_sel <= 7'h00;
    repeat (3) @(posedge clk);
    check(dot_peak_q, 32'h0);
    tend("dot scale");
    wr(8'h50, 8'hFF);
    rd(8'h50, 1);
    check(host.rbuf[0], 32'hF7);
    check(fault_detect_select_q, 32'h0);
    for (int c = 0; c < 6; c++) begin
      wr(8'h50, {c[3:0], 3'h0, c[0]});
      check(scan_rows_q, exp_rows[c]);
      check(run_not_shutdown_q, c[0]);
    end
    tend("config");
    for (int c = 0; c < 8; c++) begin
      wr(8'h52, {c[0], c[2:0], 1'b1, c[2:0]});
      check(row_pull_halfk_q, exp_halfk[c]);
      check(col_pull_halfk_q, exp_halfk[c]);
      check(row_pull_always_q, c[2]);
      check(col_pull_always_q, c[2]);
      check(phase_choice_bit_q, c[0]);
    end
    rd(8'h52, 1);
    check(host.rbuf[0], 32'hF7);
    tend("pull");
    over_temp <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h5F, {4'hF, c[1:0], c[1:0]});
      check(thermal_threshold_q, c[1:0]);
      check(derate_pct_q, exp_der[c]);
    end
    over_temp <= 1'b0;
    rd(8'h5F, 2);
    check(host.rbuf[0], 32'hF);
    check(host.rbuf[1], 32'h0);
    check(derate_pct_q, 32'h64);
    tend("thermal");
    for (int c = 0; c < 4; c++) begin
      wr(8'h60, {4'h1, c[1:0], c[1:0]});
      check(spread_enable_q, 32'h1);
      check(spread_pct_q, exp_pct[c]);
      check(spread_period_us_q, exp_per[c]);
    end
    wr(8'h60, 8'hEF);
    rd(8'h60, 1);
    check(host.rbuf[0], 32'hF);
    check(spread_enable_q, 32'h0);
    tend("spread");
    wr(8'hE2, 8'h20);
    check(pwm_freq_shift_q, 32'h0);
    wr(8'hE0, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(8'hE2, {c[2:0], 5'h00});
      check(pwm_freq_shift_q, (c == 7) ? 0 : c);
    end
    wr(8'hE0, 8'h00);
    wr(8'hE2, 8'h40);
    check(pwm_freq_shift_q, 32'h0);
    rd(8'hE0, 3);
    check({host.rbuf[0], host.rbuf[1], host.rbuf[2]}, 32'h0);
    rd(8'h8F, 1);
    check(host.rbuf[0], 32'h0);
    tend("pwm frequency");
    check(starts, 32'h0);
    wr(8'h51, 8'h20);
    wr(8'h52, 8'h00);
    wr(8'h50, 8'h03);
    check(starts, 32'h1);
    check(fault_detect_select_q, 32'h1);
    wr(8'h50, 8'h03);
    check(starts, 32'h1);
    wr(8'h50, 8'h01);
    wr(8'h50, 8'h05);
    check(starts, 32'h2);
    check(fault_detect_select_q, 32'h2);
    fault_flags <= FLAGS;
    fault_done <= 1'b1;
    @(posedge clk);
    fault_done <= 1'b0;
    repeat (300) @(posedge clk);
    rd(8'h53, 12);
    for (int i = 0; i < 12; i++) begin
      check(host.rbuf[i], {26'h0, FLAGS[6*i +: 6]});
    end
    wr(8'h53, 8'hFF);
    rd(8'h53, 1);
    check(host.rbuf[0], {26'h0, FLAGS[5:0]});
    tend("detection");
    // other ids and pages must leave the page alone
    for (int k = 0; k < 2; k++) begin
      host.wbuf[0] = 8'h77;
      host.frame((k == 0) ? 8'h40 : 8'h31, 8'h51, 1);
      check(global_current_gain_q, 32'h20);
    end
    host.frame(8'hC0, 8'h51, 1);
    check(host.oe_seen, 32'h0);
    tend("page select");
    wr(8'h8F, 8'hAD);
    check(global_current_gain_q, 32'h20);
    wr(8'h8F, 8'hAE);
    rd(8'h50, 3);
    check(host.rbuf[0], 32'h0);
    check(host.rbuf[1], 32'h0);
    check(host.rbuf[2], 32'h33);
    check(global_current_gain_q, 32'h0);
    check(row_pull_halfk_q, 32'h4);
    rd(8'h47, 1);
    check(host.rbuf[0], 32'h0);
    tend("soft reset");
    stop_test();
  end
endmodule : tb
